// ===== src/cadsp_pkg.sv
// constants and carriers of the cascadable converter serial port
// assumes one reference clock; all timing is counted in its cycles
package cadsp_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] SERIAL_MODE_CTRL_OFS        = 3'h0;
  localparam logic [2:0] CLOCK_DIVIDER_CTRL_OFS      = 3'h1;
  localparam logic [2:0] REFERENCE_POWER_CTRL_OFS    = 3'h2;
  localparam logic [2:0] GAIN_POWER_CH12_OFS         = 3'h3;
  localparam logic [2:0] GAIN_POWER_CH34_OFS         = 3'h4;
  localparam logic [2:0] GAIN_POWER_CH56_OFS         = 3'h5;
  localparam logic [2:0] CHANNEL_INPUT_CFG_OFS       = 3'h6;
  localparam logic [2:0] CHANNEL_INVERT_TEST_CFG_OFS = 3'h7;
  localparam logic [7:0] REG_RESET_VAL               = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int OPERATING_MODE_BIT    = 0;
  localparam int MIXED_MODE_BIT        = 1;
  localparam int LOOPBACK_BIT          = 3;
  localparam int DEVICE_COUNT_BIT0     = 4;
  localparam int DEVICE_COUNT_BIT2     = 6;
  localparam int SOFT_RESET_BIT        = 7;
  localparam int DECIMATION_RATE_BIT0  = 0;
  localparam int SERIAL_CLOCK_DIV_BIT0 = 2;
  localparam int MASTER_CLOCK_DIV_BIT0 = 4;
  localparam int CONTROL_ECHO_ENABLE   = 7;
  localparam int WORD_CTL_BIT          = 15;
  localparam int WORD_RW_BIT           = 14;
  localparam int WORD_DEV_LO           = 11;
  localparam int WORD_REG_LO           = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int          WORD_BITS        = 16;
  localparam logic [3:0]  LAST_BIT         = 4'hF;
  localparam logic [2:0]  MASTER_DIV_MAX   = 3'h4;
  localparam int          SAMPLE_BASE_TICKS = 256;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [0:0] {
    CADSP_IDLE  = 1'b0,
    CADSP_SHIFT = 1'b1
  } cadsp_state_t;

  typedef struct packed {
    logic [7:0][7:0] regs;
  } cadsp_regs_t;

  typedef struct packed {
    logic sclk;
    logic sdofs;
    logic sdo;
  } cadsp_link_t;

endpackage

// ===== src/cadsp_serial_port.sv
// serial port of a six-channel converter: frame master, shared shift
// register, control word decode, eight control registers, clock dividers
// assumes ref_clk is the external master clock; link inputs are synchronous
//
// What this block does
// - every word shifted msb first
// - device alone starts output frames; sdifs starts input when idle
// - mode bit clear: program, registers readable/writable
// - data mode: ignore input, send samples only
// - mixed: control accepted, top bit flags kind
// - one shift register, sample overwrites it
// - serial divider sets words per sample
// - master clock divided by one to five
// - serial clock divides by 2, 4, 8, 16
// - eight 8-bit registers, all reset zero
// - registers update on serial clock falling edge
// - control flag high: control; low invalid in program mode
// - write when rw low and address zero
// - read copies register into data, sends
// - nonzero address: decrement and forward word
// - register address field selects one register
// - low byte carries write or read value
// - mode register field layout
// - divider register field layout
// - device count bits held per device
`timescale 1ns/10ps
module cadsp_serial_port #(
  parameter int SAMPLE_BASE = cadsp_pkg::SAMPLE_BASE_TICKS
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 sdi,
  input  wire logic                 sdifs,
  input  wire logic [15:0]          conv_word,
  output cadsp_pkg::cadsp_link_t    link,
  output logic                      sample_evt,
  output logic                      ctl_invalid,
  output cadsp_pkg::cadsp_regs_t    ctrl
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    cadsp_pkg::cadsp_regs_t  r;
    logic [2:0]              mdiv_cnt;
    logic [2:0]              sdiv_cnt;
    logic [15:0]             samp_cnt;
    logic                    sclk;
    cadsp_pkg::cadsp_state_t st;
    logic [3:0]              bit_cnt;
    logic [15:0]             sr;
    logic                    pend;
    logic                    fs;
    logic                    invalid;
  } cadsp_core_t;

  cadsp_core_t s_r;
  cadsp_core_t s_nxt;
  logic [1:0]  rst_sync_r;
  logic        rst_n;

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // field decode
  // ****************************************
  logic [7:0]  mode_reg;
  logic [7:0]  clk_reg;
  logic        operating_mode_bit;
  logic        mixed_mode_bit;
  logic        loopback_bit;
  logic        control_echo_enable;
  logic [1:0]  dec_rate;
  logic [1:0]  sclk_div;
  logic [2:0]  mclk_div;
  logic        accept_ctl;
  logic        sdi_eff;

  assign mode_reg            = s_r.r.regs[cadsp_pkg::SERIAL_MODE_CTRL_OFS];
  assign operating_mode_bit  = mode_reg[cadsp_pkg::OPERATING_MODE_BIT];
  assign mixed_mode_bit      = mode_reg[cadsp_pkg::MIXED_MODE_BIT];
  assign loopback_bit        = mode_reg[cadsp_pkg::LOOPBACK_BIT];
  assign clk_reg             = s_r.r.regs[cadsp_pkg::CLOCK_DIVIDER_CTRL_OFS];
  assign control_echo_enable = clk_reg[cadsp_pkg::CONTROL_ECHO_ENABLE];
  assign dec_rate            = clk_reg[cadsp_pkg::DECIMATION_RATE_BIT0 +: 2];
  assign sclk_div            = clk_reg[cadsp_pkg::SERIAL_CLOCK_DIV_BIT0 +: 2];
  assign mclk_div            = clk_reg[cadsp_pkg::MASTER_CLOCK_DIV_BIT0 +: 3];
  assign accept_ctl          = !operating_mode_bit || mixed_mode_bit;
  assign sdi_eff             = loopback_bit ? s_r.sr[15] : sdi;

  // ****************************************
  // clock dividers and sample timer
  // ****************************************
  logic [2:0]  mdiv_lim;
  logic [2:0]  sdiv_mask;
  logic [15:0] samp_lim;
  logic        dm_tick;
  logic        sc_tick;
  logic        rise;
  logic        fall;
  logic        samp_go;

  assign mdiv_lim = (mclk_div <= cadsp_pkg::MASTER_DIV_MAX) ? mclk_div : 3'h0;
  assign dm_tick  = (s_r.mdiv_cnt == mdiv_lim);

  always_comb begin
    unique case (sclk_div)
      2'h0: sdiv_mask = 3'h0;
      2'h1: sdiv_mask = 3'h1;
      2'h2: sdiv_mask = 3'h3;
      2'h3: sdiv_mask = 3'h7;
    endcase
  end
  assign sc_tick = dm_tick && ((s_r.sdiv_cnt | ~sdiv_mask) == 3'h7);
  assign rise    = sc_tick && !s_r.sclk;
  assign fall    = sc_tick && s_r.sclk;

  always_comb begin
    unique case (dec_rate)
      2'h0: samp_lim = 16'((SAMPLE_BASE << 3) - 1);
      2'h1: samp_lim = 16'((SAMPLE_BASE << 2) - 1);
      2'h2: samp_lim = 16'((SAMPLE_BASE << 1) - 1);
      2'h3: samp_lim = 16'(SAMPLE_BASE - 1);
    endcase
  end
  assign samp_go = dm_tick && (s_r.samp_cnt >= samp_lim);

  // ****************************************
  // word decode
  // ****************************************
  logic [15:0] shifted;
  logic        word_done;
  logic [2:0]  dev_addr;
  logic [2:0]  reg_addr;
  logic        is_ctl;
  logic        is_read;
  logic        fwd_go;
  logic        wr_go;
  logic        rd_go;
  logic        bad_go;
  logic        in_start;

  assign shifted   = {s_r.sr[14:0], sdi_eff};
  assign in_start  = fall && (s_r.st == cadsp_pkg::CADSP_IDLE) && sdifs;
  assign word_done = fall && (s_r.st == cadsp_pkg::CADSP_SHIFT)
                     && (s_r.bit_cnt == cadsp_pkg::LAST_BIT);
  assign dev_addr  = shifted[cadsp_pkg::WORD_DEV_LO +: 3];
  assign reg_addr  = shifted[cadsp_pkg::WORD_REG_LO +: 3];
  assign is_ctl    = shifted[cadsp_pkg::WORD_CTL_BIT];
  assign is_read   = shifted[cadsp_pkg::WORD_RW_BIT];
  assign fwd_go    = word_done && !samp_go && accept_ctl && is_ctl && (dev_addr != 3'h0);
  assign wr_go     = word_done && !samp_go && accept_ctl && is_ctl && (dev_addr == 3'h0)
                     && !is_read;
  assign rd_go     = word_done && !samp_go && accept_ctl && is_ctl && (dev_addr == 3'h0)
                     && is_read;
  assign bad_go    = word_done && !samp_go && !operating_mode_bit && !mixed_mode_bit
                     && !is_ctl;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt         = s_r;
    s_nxt.invalid = bad_go;
    s_nxt.mdiv_cnt = dm_tick ? 3'h0 : 3'(s_r.mdiv_cnt + 3'h1);
    if (dm_tick) begin
      s_nxt.sdiv_cnt = 3'(s_r.sdiv_cnt + 3'h1);
      s_nxt.samp_cnt = samp_go ? 16'h0000 : 16'(s_r.samp_cnt + 16'h0001);
    end
    if (sc_tick) begin
      s_nxt.sclk = !s_r.sclk;
    end
    // output frames start from device side; sdifs also starts input shifting when idle
    if (rise) begin
      if (s_r.pend) begin
        s_nxt.fs      = 1'b1;
        s_nxt.pend    = 1'b0;
        s_nxt.st      = cadsp_pkg::CADSP_SHIFT;
        s_nxt.bit_cnt = 4'h0;
      end else begin
        s_nxt.fs = 1'b0;
      end
    end
    if (in_start) begin
      s_nxt.sr      = shifted;
      s_nxt.st      = cadsp_pkg::CADSP_SHIFT;
      s_nxt.bit_cnt = 4'h1;
    end else if (fall && (s_r.st == cadsp_pkg::CADSP_SHIFT)) begin
      s_nxt.sr      = shifted;
      s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
      if (word_done) begin
        s_nxt.st = cadsp_pkg::CADSP_IDLE;
      end
    end
    if (fwd_go) begin
      s_nxt.sr[cadsp_pkg::WORD_DEV_LO +: 3] = 3'(dev_addr - 3'h1);
      s_nxt.pend                           = 1'b1;
    end
    if (wr_go) begin
      s_nxt.r.regs[reg_addr] = shifted[7:0];
      if ((reg_addr == cadsp_pkg::SERIAL_MODE_CTRL_OFS)
          && shifted[cadsp_pkg::SOFT_RESET_BIT]) begin
        s_nxt.r.regs = {8{cadsp_pkg::REG_RESET_VAL}};
      end
      s_nxt.pend = control_echo_enable;
    end
    if (rd_go) begin
      s_nxt.sr[7:0] = s_r.r.regs[reg_addr];
      s_nxt.pend    = 1'b1;
    end
    if (samp_go) begin
      // mixed mode flags data with zero
      s_nxt.sr      = mixed_mode_bit ? {1'b0, conv_word[15:1]} : conv_word;
      s_nxt.pend    = 1'b1;
      s_nxt.st      = cadsp_pkg::CADSP_IDLE;
      s_nxt.bit_cnt = 4'h0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // all registers reset to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.r        <= '{regs: {8{cadsp_pkg::REG_RESET_VAL}}};
      s_r.mdiv_cnt <= 3'h0;
      s_r.sdiv_cnt <= 3'h0;
      s_r.samp_cnt <= 16'h0000;
      s_r.sclk     <= 1'b0;
      s_r.st       <= cadsp_pkg::CADSP_IDLE;
      s_r.bit_cnt  <= 4'h0;
      s_r.sr       <= 16'h0000;
      s_r.pend     <= 1'b0;
      s_r.fs       <= 1'b0;
      s_r.invalid  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link        = '{sclk: s_r.sclk, sdofs: s_r.fs, sdo: s_r.sr[15]};
  assign sample_evt  = samp_go;
  assign ctl_invalid = s_r.invalid;
  assign ctrl        = s_r.r;

  // ****************************************
  // checks
  // ****************************************
  a_sclk_tick: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (s_r.sclk != $past(s_r.sclk)) |-> $past(sc_tick))
    else $error("serial clock moved without a divider tick");

  a_msb_shift: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (fall && s_r.st == cadsp_pkg::CADSP_SHIFT && !samp_go && !wr_go && !rd_go && !fwd_go)
    |=> (s_r.sr == {$past(s_r.sr[14:0]), $past(sdi_eff)}))
    else $error("shift register did not move msb first");

  a_sample_load: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (samp_go && !mixed_mode_bit) |=> (s_r.sr == $past(conv_word)) && s_r.pend)
    else $error("sample not loaded into shift register");

  a_mixed_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (samp_go && mixed_mode_bit) |=> (s_r.sr[15] == 1'b0))
    else $error("mixed mode sample flag not clear");

  a_data_ignore: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (word_done && operating_mode_bit && !mixed_mode_bit) |=> (s_r.r == $past(s_r.r)))
    else $error("data mode accepted an incoming word");

  a_reg_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_go && !(reg_addr == 3'h0 && shifted[7]))
    |=> (s_r.r.regs[$past(reg_addr)] == $past(shifted[7:0])))
    else $error("register write lost");

  a_read_copy: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_go |=> (s_r.sr[7:0] == $past(s_r.r.regs[reg_addr])) && s_r.pend)
    else $error("read data not placed in word");

  a_fwd_dec: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    fwd_go |=> (s_r.sr[13:11] == 3'($past(dev_addr) - 3'h1)) && (s_r.r == $past(s_r.r)))
    else $error("forwarded address not decremented");

  a_bad_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (word_done && !samp_go && !operating_mode_bit && !mixed_mode_bit && !is_ctl)
    |=> ctl_invalid)
    else $error("invalid word not flagged");

  a_fs_start: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(link.sdofs) |-> $past(rise) && $past(s_r.pend) && link.sclk)
    else $error("frame sync not tied to a rising edge");

  a_mdiv_two: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (dm_tick && mclk_div == 3'h1 && $past(mclk_div) == 3'h1 && !wr_go) |=> !dm_tick)
    else $error("divide by two ticked twice in a row");

  a_mdiv_three: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (dm_tick && mclk_div == 3'h2 && !wr_go) |=> !dm_tick ##1 !dm_tick ##1 dm_tick)
    else $error("divide by three tick spacing wrong");

endmodule

// ===== test/cadsp_host_model.sv
// host serial port model facing the converter serial port
// assumes one device on the link; the device makes every clock and frame
`timescale 1ns/10ps
module cadsp_host_model (
  input  wire logic              ref_clk,
  input  cadsp_pkg::cadsp_link_t link,
  input  wire logic              tx_req,
  input  wire logic [15:0]       tx_word,
  output logic                   sdi,
  output logic                   sdifs,
  output logic                   rx_valid,
  output logic                   tx_done,
  output logic [15:0]            rx_word
);
  logic        sclk_q = 1'b0;
  logic        mine   = 1'b0;
  logic        rx_v   = 1'b0;
  logic [4:0]  cnt    = 5'h10;
  logic [4:0]  rcnt   = 5'h10;
  logic [15:0] tsh    = 16'h0000;
  logic [15:0] rsh    = 16'h0000;
  wire         rise   = link.sclk & ~sclk_q;
  wire         fall   = ~link.sclk & sclk_q;

  // msb first; a requested word's msb also driven between frames
  assign sdi      = (cnt != 5'h10) ? tsh[15] : (tx_req & tx_word[15]);
  assign sdifs    = link.sdofs;
  assign rx_word  = rsh;
  assign rx_valid = rx_v;
  assign tx_done  = rx_v & mine;

  always @(posedge ref_clk) begin
    sclk_q <= link.sclk;
    rx_v <= 1'b0;
    if (rise && link.sdofs) begin
      tsh <= tx_req ? tx_word : 16'h0000;
      mine <= tx_req;
      cnt <= 5'h00;
      rsh <= {15'h0000, link.sdo};
      rcnt <= 5'h01;
    end else if (rise && rcnt != 5'h10) begin
      rsh <= {rsh[14:0], link.sdo};
      rcnt <= rcnt + 5'h01;
      rx_v <= (rcnt == 5'h0F);
    end
    if (fall && cnt != 5'h10) begin
      tsh <= {tsh[14:0], 1'b0};
      cnt <= cnt + 5'h01;
    end
  end
endmodule

// ===== test/tb.sv
// self-checking bench of the converter serial port
// assumes the host model on the link and a shortened sample base
`timescale 1ns/10ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end
module tb;
  logic                   ref_clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic [15:0]            conv_word = 16'hB5C3;
  logic                   tx_req = 1'b0;
  logic [15:0]            tx_word = 16'h0000;
  logic                   sdi;
  logic                   sdifs;
  logic                   sample_evt;
  logic                   ctl_invalid;
  logic                   rx_valid;
  logic                   tx_done;
  logic [15:0]            rx_word;
  logic [15:0]            w;
  cadsp_pkg::cadsp_link_t link;
  cadsp_pkg::cadsp_regs_t ctrl;
  logic [7:0]             e [8] = '{default: 8'h00};
  int                     n_errors = 0;
  int                     samples_checked = 0;
  int                     inv;
  int                     c;

  cadsp_serial_port #(.SAMPLE_BASE(16)) cadsp_serial_port_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .sdi(sdi), .sdifs(sdifs),
    .conv_word(conv_word), .link(link), .sample_evt(sample_evt),
    .ctl_invalid(ctl_invalid), .ctrl(ctrl)
  );
  cadsp_host_model cadsp_host_model_inst (
    .ref_clk(ref_clk), .link(link), .tx_req(tx_req), .tx_word(tx_word),
    .sdi(sdi), .sdifs(sdifs), .rx_valid(rx_valid), .tx_done(tx_done),
    .rx_word(rx_word)
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ****
  // tasks
  // ****
  function automatic logic [15:0] cw(input logic rw, input logic [2:0] dv,
                                     input logic [2:0] rg, input logic [7:0] d);
    return {1'b1, rw, dv, rg, d};
  endfunction

  task automatic send(input logic [15:0] x, output int k);
    int n;
    n = 0;
    @(posedge ref_clk);
    tx_word <= x;
    tx_req <= 1'b1;
    do begin
      @(negedge ref_clk);
      n++;
    end while (tx_done !== 1'b1 && n < 2000);
    if (n >= 2000) n_errors++;
    k = (ctl_invalid === 1'b1) ? 1 : 0;
    @(posedge ref_clk);
    tx_req <= 1'b0;
    repeat (24) begin
      @(negedge ref_clk);
      if (ctl_invalid === 1'b1) k++;
    end
  endtask

  task automatic recv(output logic [15:0] x);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rx_valid !== 1'b1 && n < 2000);
    if (n >= 2000) n_errors++;
    x = rx_word;
  endtask

  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    send(cw(1'b0, 3'h0, r, d), inv);
    e[r] = d;
  endtask

  task automatic gap(input logic s, output int cy);
    logic p;
    logic v;
    int k;
    p = 1'b1;
    k = 0;
    cy = 0;
    repeat (1000) begin
      @(negedge ref_clk);
      v = s ? link.sclk : sample_evt;
      if (k == 1) cy++;
      if (v === 1'b1 && p === 1'b0 && k < 2) k++;
      p = v;
    end
  endtask

  task automatic chk_regs();
    for (int i = 0; i < 8; i++) `CHK(ctrl.regs[i], e[i])
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****
  // tests
  // ****
  initial begin
    #1500000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    chk_regs();
    gap(1'b0, c);
    `CHK(c, 128)
    for (int r = 2; r < 8; r++) begin
      wr(r[2:0], 8'h5A ^ r[7:0]);
      `CHK(inv, 0)
    end
    chk_regs();
    send(cw(1'b1, 3'h0, 3'h3, 8'h00), inv);
    recv(w);
    `CHK(w, cw(1'b1, 3'h0, 3'h3, e[3]))
    send(cw(1'b0, 3'h2, 3'h4, 8'hC7), inv);
    recv(w);
    `CHK(w, cw(1'b0, 3'h1, 3'h4, 8'hC7))
    send(16'h0455, inv);
    `CHK(inv, 1)
    chk_regs();
    wr(3'h0, 8'h80);
    e = '{default: 8'h00};
    chk_regs();
    wr(3'h1, 8'h24);
    gap(1'b0, c);
    `CHK(c, 384)
    gap(1'b1, c);
    `CHK(c, 12)
    wr(3'h1, 8'hA4);
    wr(3'h2, 8'h11);
    recv(w);
    `CHK(w, cw(1'b0, 3'h0, 3'h2, 8'h11))
    wr(3'h1, 8'h24);
    wr(3'h0, 8'h03);
    recv(w);
    `CHK(w, {1'b0, conv_word[15:1]})
    wr(3'h4, 8'h3C);
    send(16'h0466, inv);
    `CHK(inv, 0)
    wr(3'h0, 8'h01);
    send(cw(1'b0, 3'h0, 3'h5, 8'h99), inv);
    chk_regs();
    @(posedge ref_clk);
    conv_word <= 16'h1E2D;
    recv(w);
    `CHK(w, 16'h1E2D)
    give_verdict();
  end
endmodule
